// ==== src/tro_opcode_handler.sv ====
// Opcode interpreter for readout settings and channel enables, Avalon-MM slave
`timescale 1ns/100ps
module tro_opcode_handler #(
  parameter int NUM_CH = 128
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Event stream from the converters
  input  wire logic        hit_in,
  input  wire logic        event_end_in,
  // Configuration outputs
  output logic             header_en_out,
  output logic [3:0]       hit_limit_out,
  output logic             error_mark_en_out,
  output logic             bypass_en_out,
  output logic [10:0]      error_type_en_out,
  output logic [2:0]       level_one_hit_buffer_size_out,
  output logic [NUM_CH-1:0] channel_en_out,
  // Limited event stream
  output logic             hit_pass_out,
  output logic             size_err_out,
  output logic [15:0]      size_err_word_out,
  output logic             trailer_out
);

  localparam int NWORDS = NUM_CH / 16;
  localparam int NCONV  = NUM_CH / 32;

  tro_pkg::tro_state_t state;
  logic [7:0]  op_code;
  logic [7:0]  op_arg;
  logic [3:0]  words_left;
  logic [3:0]  word_idx;
  logic        ack;
  logic [15:0] rd_word;
  logic [15:0] size_err_count;
  logic [6:0]  ch_idx;
  logic [3:0]  pat_word;

  // One-cycle wait: each access is answered on the edge after it is seen
  wire req       = (avs_read_in || avs_write_in) && !ack;
  wire cmd_acc   = req && (avs_address_in == tro_pkg::OFF_CMD_DATA);
  wire cmd_wr    = cmd_acc && avs_write_in;
  wire cmd_rd    = cmd_acc && avs_read_in;
  wire [7:0] wop = avs_writedata_in[15:8];
  wire [7:0] warg = avs_writedata_in[7:0];
  wire [15:0] wdat = avs_writedata_in[15:0];
  wire par_wr    = cmd_wr && (state == tro_pkg::TRO_WPAR);
  wire par_rd    = cmd_rd && (state == tro_pkg::TRO_RPAR);
  wire op_wr     = cmd_wr && (state == tro_pkg::TRO_IDLE);
  wire last_word = (words_left == 4'h1);

  assign ch_idx   = 7'(warg);
  assign pat_word = 4'(word_idx + ((op_code == tro_pkg::OP_PAT32_WR) ? {op_arg[2:0], 1'b0} : 4'h0));

  // Bus handshake: waitrequest falls for exactly one cycle per access
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack                 <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack                 <= req;
      avs_waitrequest_out <= !req;
    end
  end

  // Parameter word count for each opcode that carries data
  function automatic logic [3:0] param_words(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    unique case (op)
      tro_pkg::OP_HDR_RD, tro_pkg::OP_HITLIM_WR, tro_pkg::OP_HITLIM_RD,
      tro_pkg::OP_ERRTYP_WR, tro_pkg::OP_ERRTYP_RD,
      tro_pkg::OP_BUFSZ_WR, tro_pkg::OP_BUFSZ_RD: n = 4'h1;
      tro_pkg::OP_PAT_WR, tro_pkg::OP_PAT_RD:     n = 4'(NWORDS);
      tro_pkg::OP_PAT32_WR, tro_pkg::OP_PAT32_RD: n = 4'h2;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  function automatic logic is_read_op(input logic [7:0] op);
    return op == tro_pkg::OP_HDR_RD || op == tro_pkg::OP_HITLIM_RD ||
           op == tro_pkg::OP_ERRTYP_RD || op == tro_pkg::OP_BUFSZ_RD ||
           op == tro_pkg::OP_PAT_RD || op == tro_pkg::OP_PAT32_RD;
  endfunction

  // Command sequencer; writes at the port while waiting are never taken as opcodes
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state      <= tro_pkg::TRO_IDLE;
      op_code    <= 8'h00;
      op_arg     <= 8'h00;
      words_left <= 4'h0;
      word_idx   <= 4'h0;
    end else begin
      unique case (state)
        tro_pkg::TRO_IDLE: begin
          if (op_wr && param_words(wop) != 4'h0) begin
            op_code    <= wop;
            op_arg     <= warg;
            words_left <= param_words(wop);
            word_idx   <= 4'h0;
            state      <= is_read_op(wop) ? tro_pkg::TRO_RPAR : tro_pkg::TRO_WPAR;
          end
        end
        tro_pkg::TRO_WPAR: begin
          if (par_wr) begin
            words_left <= words_left - 4'h1;
            word_idx   <= word_idx + 4'h1;
            if (last_word) begin
              state <= tro_pkg::TRO_IDLE;
            end
          end
        end
        tro_pkg::TRO_RPAR: begin
          if (par_rd) begin
            words_left <= words_left - 4'h1;
            word_idx   <= word_idx + 4'h1;
            if (last_word) begin
              state <= tro_pkg::TRO_IDLE;
            end
          end
        end
        default: state <= tro_pkg::TRO_IDLE;
      endcase
    end
  end

  // Readout control bits set by bare opcodes and parameter writes
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      header_en_out                 <= tro_pkg::HDR_RST;
      hit_limit_out                 <= tro_pkg::HITLIM_RST;
      error_mark_en_out             <= tro_pkg::EMARK_RST;
      bypass_en_out                 <= tro_pkg::BYP_RST;
      error_type_en_out             <= tro_pkg::ERRTYP_RST;
      level_one_hit_buffer_size_out <= tro_pkg::BUFSZ_RST;
    end else if (op_wr) begin
      if (wop == tro_pkg::OP_HDR_ON)   header_en_out     <= 1'b1;
      if (wop == tro_pkg::OP_HDR_OFF)  header_en_out     <= 1'b0;
      if (wop == tro_pkg::OP_EMARK_ON) error_mark_en_out <= 1'b1;
      if (wop == tro_pkg::OP_EMARK_OFF) error_mark_en_out <= 1'b0;
      if (wop == tro_pkg::OP_BYP_ON)   bypass_en_out     <= 1'b1;
      if (wop == tro_pkg::OP_BYP_OFF)  bypass_en_out     <= 1'b0;
    end else if (par_wr) begin
      if (op_code == tro_pkg::OP_HITLIM_WR) hit_limit_out <= wdat[3:0];
      if (op_code == tro_pkg::OP_ERRTYP_WR) error_type_en_out <= wdat[10:0];
      if (op_code == tro_pkg::OP_BUFSZ_WR) begin
        level_one_hit_buffer_size_out <= wdat[2:0];
      end
    end
  end

  // Channel enables: applied at once, never waiting for acquisition to stop
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel_en_out <= '1;
    end else if (op_wr) begin
      if (wop == tro_pkg::OP_CH_ON && 32'(warg) < NUM_CH) begin
        channel_en_out[ch_idx] <= 1'b1;
      end
      if (wop == tro_pkg::OP_CH_OFF && 32'(warg) < NUM_CH) begin
        channel_en_out[ch_idx] <= 1'b0;
      end
      if (wop == tro_pkg::OP_ALL_ON)  channel_en_out <= '1;
      if (wop == tro_pkg::OP_ALL_OFF) channel_en_out <= '0;
    end else if (par_wr && (op_code == tro_pkg::OP_PAT_WR ||
                            (op_code == tro_pkg::OP_PAT32_WR && 32'(op_arg) < NCONV))) begin
      channel_en_out[pat_word*16 +: 16] <= wdat;
    end
  end

  // Word offered to a parameter read
  always_comb begin
    rd_word = 16'h0000;
    unique case (op_code)
      tro_pkg::OP_HDR_RD:    rd_word = {15'h0000, header_en_out};
      tro_pkg::OP_HITLIM_RD: rd_word = {12'h000, hit_limit_out};
      tro_pkg::OP_ERRTYP_RD: rd_word = {5'h00, error_type_en_out};
      tro_pkg::OP_BUFSZ_RD:  rd_word = {13'h0000, level_one_hit_buffer_size_out};
      tro_pkg::OP_PAT_RD:    rd_word = channel_en_out[word_idx*16 +: 16];
      tro_pkg::OP_PAT32_RD: begin
        if (32'(op_arg) < NCONV) begin
          rd_word = channel_en_out[({op_arg[2:0], 1'b0} + word_idx)*16 +: 16];
        end
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data; unmapped offsets and reads outside a read command return zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (req && avs_read_in) begin
      unique case (avs_address_in)
        tro_pkg::OFF_CMD_DATA: avs_readdata_out <= par_rd ? {16'h0000, rd_word} : 32'h0;
        tro_pkg::OFF_STATUS:   avs_readdata_out <= {24'h0, words_left, 2'b00, state};
        tro_pkg::OFF_HIT_CNT:  avs_readdata_out <= {16'h0000, size_err_count};
        default:               avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Count of overflowed events, useful to tune the hit limit
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      size_err_count <= 16'h0000;
    end else if (size_err_out && size_err_count != 16'hFFFF) begin
      size_err_count <= size_err_count + 16'h0001;
    end
  end

  tro_hit_limiter u_limit (
    .ref_clk_in        (ref_clk_in),
    .rst_b_in          (rst_b_in),
    .hit_limit_code_in (hit_limit_out),
    .header_en_in      (header_en_out),
    .hit_in            (hit_in),
    .event_end_in      (event_end_in),
    .hit_pass_out      (hit_pass_out),
    .size_err_out      (size_err_out),
    .size_err_word_out (size_err_word_out),
    .trailer_out       (trailer_out)
  );

  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_last_param;
    (state != tro_pkg::TRO_IDLE) && (par_wr || par_rd) && last_word;
  endsequence

  property p_wait_params;
    (state == tro_pkg::TRO_IDLE) && cmd_wr && param_words(wop) == 4'h2 |=>
      (state != tro_pkg::TRO_IDLE);
  endproperty
  a_wait_params: assert property (p_wait_params) else $error("left wait early");

  property p_finish;
    s_last_param |=> (state == tro_pkg::TRO_IDLE);
  endproperty
  a_finish: assert property (p_finish) else $error("command not finished");

  property p_hdr_rd;
    par_rd && op_code == tro_pkg::OP_HDR_RD |=> avs_readdata_out[0] == $past(header_en_out);
  endproperty
  a_hdr_rd: assert property (p_hdr_rd) else $error("header status wrong");

  property p_hitlim;
    par_wr && op_code == tro_pkg::OP_HITLIM_WR |=> hit_limit_out == $past(wdat[3:0]);
  endproperty
  a_hitlim: assert property (p_hitlim) else $error("hit limit not set");

  property p_errword;
    size_err_out |-> (size_err_word_out == tro_pkg::SIZE_ERR_WORD) ##1
      (trailer_out || !$past(header_en_out, 2));
  endproperty
  a_errword: assert property (p_errword) else $error("error word wrong");

  property p_ch_on;
    op_wr && wop == tro_pkg::OP_CH_ON && 32'(warg) < NUM_CH |=> channel_en_out[$past(ch_idx)];
  endproperty
  a_ch_on: assert property (p_ch_on) else $error("channel not enabled");

  property p_all_off;
    op_wr && wop == tro_pkg::OP_ALL_OFF |=> channel_en_out == '0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("channels not cleared");

  property p_emark;
    op_wr && wop == tro_pkg::OP_EMARK_OFF |=> !error_mark_en_out ##1
      ($stable(error_mark_en_out) || $past(op_wr));
  endproperty
  a_emark: assert property (p_emark) else $error("error mark not off");

endmodule

// ==== shared/tro_pkg.sv ====
// Package of constants and types for the readout/channel opcode handler
package tro_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_CMD_DATA = 4'h0;
  localparam logic [3:0] OFF_STATUS   = 4'h4;
  localparam logic [3:0] OFF_HIT_CNT  = 4'h8;

  // Opcode classes, upper byte of the command word
  localparam logic [7:0] OP_HDR_ON     = 8'h30;
  localparam logic [7:0] OP_HDR_OFF    = 8'h31;
  localparam logic [7:0] OP_HDR_RD     = 8'h32;
  localparam logic [7:0] OP_HITLIM_WR  = 8'h33;
  localparam logic [7:0] OP_HITLIM_RD  = 8'h34;
  localparam logic [7:0] OP_EMARK_ON   = 8'h35;
  localparam logic [7:0] OP_EMARK_OFF  = 8'h36;
  localparam logic [7:0] OP_BYP_ON     = 8'h37;
  localparam logic [7:0] OP_BYP_OFF    = 8'h38;
  localparam logic [7:0] OP_ERRTYP_WR  = 8'h39;
  localparam logic [7:0] OP_ERRTYP_RD  = 8'h3A;
  localparam logic [7:0] OP_BUFSZ_WR   = 8'h3B;
  localparam logic [7:0] OP_BUFSZ_RD   = 8'h3C;
  localparam logic [7:0] OP_CH_ON      = 8'h40;
  localparam logic [7:0] OP_CH_OFF     = 8'h41;
  localparam logic [7:0] OP_ALL_ON     = 8'h42;
  localparam logic [7:0] OP_ALL_OFF    = 8'h43;
  localparam logic [7:0] OP_PAT_WR     = 8'h44;
  localparam logic [7:0] OP_PAT_RD     = 8'h45;
  localparam logic [7:0] OP_PAT32_WR   = 8'h46;
  localparam logic [7:0] OP_PAT32_RD   = 8'h47;

  // Reset values
  localparam logic [3:0]  HITLIM_RST  = 4'h9;
  localparam logic [2:0]  BUFSZ_RST   = 3'h7;
  localparam logic [10:0] ERRTYP_RST  = 11'h000;
  localparam logic        HDR_RST     = 1'b0;
  localparam logic        EMARK_RST   = 1'b1;
  localparam logic        BYP_RST     = 1'b0;

  // Overflow error word flag
  localparam logic [15:0] SIZE_ERR_WORD = 16'h1000;
  localparam logic [3:0]  HITLIM_NONE   = 4'h9;

  // Interpreter states, Gray along idle -> write params -> read params
  typedef enum logic [1:0] {
    TRO_IDLE = 2'b00,
    TRO_WPAR = 2'b01,
    TRO_RPAR = 2'b11
  } tro_state_t;

endpackage

// ==== src/tro_hit_limiter.sv ====
// Per-event hit limiter that appends the size-overflow error word
`timescale 1ns/100ps
module tro_hit_limiter (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  // Configuration
  input  wire logic [3:0]  hit_limit_code_in,
  input  wire logic        header_en_in,
  // Event stream
  input  wire logic        hit_in,
  input  wire logic        event_end_in,
  // Results
  output logic             hit_pass_out,
  output logic             size_err_out,
  output logic [15:0]      size_err_word_out,
  output logic             trailer_out
);

  logic [8:0] hit_count;
  logic [8:0] limit;
  logic       over;

  // Decode limit: 0, then powers of two up to 128
  always_comb begin
    if (hit_limit_code_in == 4'h0) begin
      limit = 9'h000;
    end else begin
      limit = 9'h001 << (hit_limit_code_in - 4'h1);
    end
  end

  // Codes above the no-limit code are meaningless and also treated as unlimited
  assign over = (hit_limit_code_in < tro_pkg::HITLIM_NONE) && (hit_count >= limit);

  // Hit counter per event; saturates so a long burst cannot wrap under the limit
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hit_count <= 9'h000;
    end else if (event_end_in) begin
      hit_count <= 9'h000;
    end else if (hit_in && hit_count != 9'h1FF) begin
      hit_count <= hit_count + 9'h001;
    end
  end

  // Overflow is remembered until the event closes
  logic dropped;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dropped <= 1'b0;
    end else if (event_end_in) begin
      dropped <= 1'b0;
    end else if (hit_in && over) begin
      dropped <= 1'b1;
    end
  end

  // Error word comes at event end, and trailer one cycle later so it follows
  logic trail_pend;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hit_pass_out      <= 1'b0;
      size_err_out      <= 1'b0;
      size_err_word_out <= 16'h0000;
      trailer_out       <= 1'b0;
      trail_pend        <= 1'b0;
    end else begin
      hit_pass_out      <= hit_in && !over && !event_end_in;
      size_err_out      <= event_end_in && (dropped || (hit_in && over));
      size_err_word_out <= tro_pkg::SIZE_ERR_WORD;
      trail_pend        <= event_end_in && header_en_in;
      trailer_out       <= trail_pend;
    end
  end

endmodule

// ==== dv/tro_host_model.sv ====
// Bus host model that drives the opcode handler's Avalon-MM slave port
`timescale 1ns/100ps
module tro_host_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Avalon-MM master side
  output logic [3:0]       avm_address_out,
  output logic             avm_read_out,
  output logic             avm_write_out,
  output logic [31:0]      avm_writedata_out,
  input  wire logic [31:0] avm_readdata_in,
  input  wire logic        avm_waitrequest_in
);
  // Idle bus from time zero
  initial begin
    avm_address_out   = 4'h0;
    avm_read_out      = 1'b0;
    avm_write_out     = 1'b0;
    avm_writedata_out = 32'h0000_0000;
  end

  // One transfer; a random idle gap makes the host sometimes slow to ask
  task automatic xfer(input logic is_wr, input logic [3:0] a, input logic [15:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    repeat ($urandom_range(2, 0)) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    avm_address_out   <= a;
    avm_write_out     <= is_wr;
    avm_read_out      <= ~is_wr;
    avm_writedata_out <= {16'h0000, d};
    ok = 1'b0;
    q  = 32'h0000_0000;
    // Request stays up until waitrequest is sampled low, bounded wait
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge ref_clk_in);
      if (avm_waitrequest_in === 1'b0) begin
        ok = 1'b1;
        q  = avm_readdata_in;
      end
    end
    // Released data lines must not keep showing the last word
    avm_read_out      <= 1'b0;
    avm_write_out     <= 1'b0;
    avm_writedata_out <= ~avm_writedata_out;
  endtask
endmodule

// ==== dv/tro_opcode_handler_tb.sv ====
// Self-checking bench for the readout and channel opcode handler
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tro_opcode_handler_tb;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic hit_in = 1'b0;
  logic event_end_in = 1'b0;
  logic [3:0] addr;
  logic rd, wr, wreq, hdr, emark, byp, hpass, serr, trl, ok;
  logic [31:0] wdata, rdata, q;
  logic [3:0] hlim;
  logic [10:0] etyp;
  logic [2:0] bsz;
  logic [15:0] sword, eword, w;
  logic [127:0] chen, exp_ch;
  int err_count, tests_run, i, k, n, cyc, npass, nerr, ntrl, ecyc, tcyc;

  // 200 MHz clock
  always #2.5 ref_clk_in = ~ref_clk_in;

  tro_host_model host_u (.ref_clk_in(ref_clk_in), .avm_address_out(addr),
    .avm_read_out(rd), .avm_write_out(wr), .avm_writedata_out(wdata),
    .avm_readdata_in(rdata), .avm_waitrequest_in(wreq));

  tro_opcode_handler #(.NUM_CH(128)) dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .hit_in(hit_in),
    .event_end_in(event_end_in), .header_en_out(hdr), .hit_limit_out(hlim),
    .error_mark_en_out(emark), .bypass_en_out(byp), .error_type_en_out(etyp),
    .level_one_hit_buffer_size_out(bsz), .channel_en_out(chen), .hit_pass_out(hpass),
    .size_err_out(serr), .size_err_word_out(sword), .trailer_out(trl));

  // Pulse monitor; counters are cleared on the falling edge to avoid races
  always @(posedge ref_clk_in) begin
    cyc++;
    if (hpass === 1'b1) npass++;
    if (trl === 1'b1) begin ntrl++; tcyc = cyc; end
    if (serr === 1'b1) begin nerr++; ecyc = cyc; eword = sword; end
  end

  // Hit count allowed by a limit code; 9 means unlimited
  function automatic int lim_of(input logic [3:0] c);
    return (c == 4'h9) ? 1000 : ((c < 4'h2) ? int'(c) : (1 << (c - 1)));
  endfunction

  task automatic test_done();
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Bus access; a lost handshake ends the run
  task automatic acc(input logic is_wr, input logic [3:0] a, input logic [15:0] d);
    host_u.xfer(is_wr, a, d, q, ok);
    if (!ok) begin err_count++; test_done(); end
    @(negedge ref_clk_in);
  endtask
  task automatic op(input logic [7:0] o, input logic [7:0] arg);
    acc(1'b1, tro_pkg::OFF_CMD_DATA, {o, arg});
  endtask
  task automatic rdchk(input string nm, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, tro_pkg::OFF_CMD_DATA, 16'h0000);
    `CHK(nm, e, q[15:0] & m)
  endtask

  // One event of three hits under a given limit code
  task automatic run_ev(input logic [3:0] c);
    int lim;
    lim = lim_of(c);
    op(tro_pkg::OP_HITLIM_WR, 8'h00);
    acc(1'b1, tro_pkg::OFF_CMD_DATA, {12'h000, c});
    npass = 0; nerr = 0; ntrl = 0; ecyc = 0; tcyc = 0;
    repeat (3) begin
      @(posedge ref_clk_in) hit_in <= 1'b1;
      @(posedge ref_clk_in) hit_in <= 1'b0;
    end
    @(posedge ref_clk_in) event_end_in <= 1'b1;
    @(posedge ref_clk_in) event_end_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    `CHK("passed", (lim < 3) ? lim : 3, npass)
    `CHK("size_err", (lim < 3) ? 1 : 0, nerr)
    `CHK("trailer", 1, ntrl)
    if (lim < 3) begin
      `CHK("err_word", tro_pkg::SIZE_ERR_WORD, eword)
      `CHK("trl_after_err", ecyc + 1, tcyc)
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(1));
    repeat (4) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(negedge ref_clk_in);
    `CHK("rst_cfg", {tro_pkg::HDR_RST, tro_pkg::HITLIM_RST, tro_pkg::EMARK_RST,
      tro_pkg::BYP_RST, tro_pkg::ERRTYP_RST, tro_pkg::BUFSZ_RST},
      {hdr, hlim, emark, byp, etyp, bsz})
    `CHK("rst_ch", {128{1'b1}}, chen)
    for (i = 0; i < 2; i++) begin
      op(i ? tro_pkg::OP_HDR_OFF : tro_pkg::OP_HDR_ON, 8'h00);
      `CHK("hdr", i == 0, hdr)
      op(tro_pkg::OP_HDR_RD, 8'h00);
      rdchk("hdr_rd", 16'h0001, {15'h0000, i == 0});
      op(i ? tro_pkg::OP_EMARK_ON : tro_pkg::OP_EMARK_OFF, 8'h00);
      `CHK("emark", i == 1, emark)
      op(i ? tro_pkg::OP_BYP_OFF : tro_pkg::OP_BYP_ON, 8'h00);
      `CHK("bypass", i == 0, byp)
    end
    for (i = 0; i < 10; i++) begin
      w = 16'($urandom());
      op(tro_pkg::OP_HITLIM_WR, 8'h00);
      acc(1'b1, tro_pkg::OFF_CMD_DATA, {w[15:4], 4'(i)});
      `CHK("hitlim", 4'(i), hlim)
      op(tro_pkg::OP_HITLIM_RD, 8'h00);
      rdchk("hitlim_rd", 16'h000F, 16'(i));
      op(tro_pkg::OP_BUFSZ_WR, 8'h00);
      acc(1'b1, tro_pkg::OFF_CMD_DATA, w);
      `CHK("bufsz", w[2:0], bsz)
      op(tro_pkg::OP_BUFSZ_RD, 8'h00);
      rdchk("bufsz_rd", 16'h0007, {13'h0000, w[2:0]});
      op(tro_pkg::OP_ERRTYP_WR, 8'h00);
      acc(1'b1, tro_pkg::OFF_CMD_DATA, ~w);
      `CHK("errtyp", ~w[10:0], etyp)
      op(tro_pkg::OP_ERRTYP_RD, 8'h00);
      rdchk("errtyp_rd", 16'h07FF, {5'h00, ~w[10:0]});
    end
    // Channel traffic while hits keep arriving
    @(posedge ref_clk_in) hit_in <= 1'b1;
    op(tro_pkg::OP_ALL_OFF, 8'h00);
    exp_ch = '0;
    `CHK("all_off", exp_ch, chen)
    for (i = 0; i < 12; i++) begin
      n = (i == 11) ? 128 : $urandom_range(127, 0);
      k = (i < 4) ? 1 : $urandom_range(1, 0);
      op(k ? tro_pkg::OP_CH_ON : tro_pkg::OP_CH_OFF, 8'(n));
      if (n < 128) exp_ch[n] = k[0];
      `CHK("ch_one", exp_ch, chen)
    end
    op(tro_pkg::OP_ALL_ON, 8'h00);
    exp_ch = '1;
    `CHK("all_on", exp_ch, chen)
    @(posedge ref_clk_in) hit_in <= 1'b0;
    op(tro_pkg::OP_PAT_WR, 8'h00);
    for (k = 0; k < 8; k++) begin
      w = (k == 3) ? {tro_pkg::OP_ALL_ON, 8'h00} : 16'($urandom());
      acc(1'b1, tro_pkg::OFF_CMD_DATA, w);
      exp_ch[16 * k +: 16] = w;
      if (k == 2) begin
        acc(1'b0, tro_pkg::OFF_STATUS, 16'h0000);
        `CHK("status_wait", 8'h51, {q[7:4], 2'b00, q[1:0]})
      end
    end
    `CHK("pattern", exp_ch, chen)
    op(tro_pkg::OP_PAT_RD, 8'h00);
    for (k = 0; k < 8; k++) begin
      rdchk("pat_rd", 16'hFFFF, exp_ch[16 * k +: 16]);
      if (k == 0) acc(1'b1, tro_pkg::OFF_CMD_DATA, 16'h4300);
    end
    `CHK("pat_kept", exp_ch, chen)
    for (n = 0; n < 4; n++) begin
      op(tro_pkg::OP_PAT32_WR, 8'(n));
      for (k = 0; k < 2; k++) begin
        w = 16'($urandom());
        acc(1'b1, tro_pkg::OFF_CMD_DATA, w);
        exp_ch[32 * n + 16 * k +: 16] = w;
      end
      `CHK("pat32", exp_ch, chen)
      op(tro_pkg::OP_PAT32_RD, 8'(n));
      for (k = 0; k < 2; k++) rdchk("pat32_rd", 16'hFFFF, exp_ch[32 * n + 16 * k +: 16]);
    end
    acc(1'b0, tro_pkg::OFF_STATUS, 16'h0000);
    `CHK("status_idle", 2'b00, q[1:0])
    rdchk("idle_data", 16'hFFFF, 16'h0000);
    acc(1'b0, 4'hC, 16'h0000);
    `CHK("unmapped", 32'h0000_0000, q)
    op(tro_pkg::OP_HDR_ON, 8'h00);
    for (i = 0; i < 5; i++) run_ev((i == 4) ? 4'h9 : 4'(i));
    // Codes 0, 1 and 2 each overflow one three-hit event
    acc(1'b0, tro_pkg::OFF_HIT_CNT, 16'h0000);
    `CHK("ovf_count", 32'h0000_0003, q)
    test_done();
  end
endmodule
